// File: aod_diag_record.sv
// diagnostic record and output area of the two-channel analog output
`timescale 1ns/1ps

module aod_diag_record #(
    parameter int BLINK_HALF_US = aod_pkg::BLINK_HALF_US
) (
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        rec_rd_en_in,
    input  wire logic [4:0]  rec_rd_addr_in,
    output logic      [7:0]  rec_rd_data_out,
    output logic             rec_rd_valid_out,
    input  wire logic        out_wr_en_in,
    input  wire logic [1:0]  out_wr_offset_in,
    input  wire logic [15:0] out_wr_data_in,
    output logic      [15:0] channel0_output_value_out,
    output logic      [15:0] channel1_output_value_out,
    input  wire logic [1:0]  cfg_err_in,
    input  wire logic [1:0]  wire_break_in,
    input  wire logic        diag_ovf_in,
    input  wire logic        comm_err_in,
    input  wire logic        bus_comm_ok_in,
    input  wire logic        bus_supply_err_in,
    output logic             run_led_out,
    output logic             module_fault_indicator_out,
    output logic      [1:0]  chan_led_out,
    output logic      [7:0]  input_area_bytes_out
);

    localparam int NCH   = 2;
    localparam int ERR_W = 6;

    typedef struct packed {
        logic [15:0]        ch0_val;
        logic [15:0]        ch1_val;
        logic [7:0]         ext_err;
        logic [7:0]         summary;
        logic [1:0][7:0]    ch_err;
        logic [ERR_W-1:0]   prev_vec;
        logic [31:0]        stamp;
        logic [7:0]         rd_data;
        logic               rd_valid;
    } aod_rec_s;

    aod_rec_s          st_r;
    aod_rec_s          st_nxt;
    logic [ERR_W-1:0]  err_vec;
    logic              diag_event;
    logic [NCH-1:0]    chan_any;

    aod_tick_if tick_bus ();

    ////////////////////////////////////////////////////////////////////
    // record byte lookup, used by the read port
    function automatic logic [7:0] aod_rec_byte(
        input logic [4:0] addr,
        input aod_rec_s   s
    );
        logic [7:0] b;
        b = aod_pkg::BYTE_ZERO;
        unique case (addr)
            aod_pkg::REC_EXT_ERR: b = s.ext_err;
            // kind code, reserved top bit zero
            aod_pkg::REC_KIND:    b = {1'b0, aod_pkg::KIND_ANA_OUT};
            aod_pkg::REC_BITS_PER_CH: b = aod_pkg::DIAG_BITS;
            aod_pkg::REC_CHAN_COUNT:  b = aod_pkg::CHAN_COUNT;
            aod_pkg::REC_SUMMARY: b = s.summary;
            aod_pkg::REC_CH0:     b = s.ch_err[0];
            aod_pkg::REC_CH1:     b = s.ch_err[1];
            aod_pkg::REC_STAMP0:  b = s.stamp[7:0];
            aod_pkg::REC_STAMP1:  b = s.stamp[15:8];
            aod_pkg::REC_STAMP2:  b = s.stamp[23:16];
            aod_pkg::REC_STAMP3:  b = s.stamp[31:24];
            default:              b = aod_pkg::BYTE_ZERO;
        endcase
        return b;
    endfunction : aod_rec_byte

    ////////////////////////////////////////////////////////////////////
    // error sources gathered, a new bit marks a diagnostic event
    assign err_vec = {comm_err_in, diag_ovf_in,
                      wire_break_in[1], cfg_err_in[1],
                      wire_break_in[0], cfg_err_in[0]};
    assign diag_event = |(err_vec & ~st_r.prev_vec);
    assign chan_any   = cfg_err_in | wire_break_in;

    // next state of the whole record
    always_comb begin
        st_nxt          = st_r;
        st_nxt.prev_vec = err_vec;
        // extended error flags, rest reserved zero
        st_nxt.ext_err  = '0;
        st_nxt.ext_err[aod_pkg::EXT_OVF_BIT]  = diag_ovf_in;
        st_nxt.ext_err[aod_pkg::EXT_COMM_BIT] = comm_err_in;
        st_nxt.summary  = '0;
        for (int i = 0; i < NCH; i++) begin
            // one summary bit per channel group
            st_nxt.summary[aod_pkg::SUM_GRP0_BIT + i] = chan_any[i];
            st_nxt.ch_err[i] = '0;
            st_nxt.ch_err[i][aod_pkg::CH_CFG_BIT] = cfg_err_in[i];
            st_nxt.ch_err[i][aod_pkg::CH_WB_BIT]  = wire_break_in[i];
        end
        // ticker captured on a new error
        if (diag_event) begin
            st_nxt.stamp = tick_bus.count;
        end
        // host places channel values at +0 and +2
        if (out_wr_en_in) begin
            if (out_wr_offset_in == aod_pkg::OUT_OFS_CH0) begin
                st_nxt.ch0_val = out_wr_data_in;
            end else if (out_wr_offset_in == aod_pkg::OUT_OFS_CH1) begin
                st_nxt.ch1_val = out_wr_data_in;
            end
        end
        // byte read of the record, answered next cycle
        st_nxt.rd_valid = rec_rd_en_in;
        if (rec_rd_en_in) begin
            st_nxt.rd_data = aod_rec_byte(rec_rd_addr_in, st_r);
        end
    end

    // record storage
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign rec_rd_data_out           = st_r.rd_data;
    assign rec_rd_valid_out          = st_r.rd_valid;
    assign channel0_output_value_out = st_r.ch0_val;
    assign channel1_output_value_out = st_r.ch1_val;
    assign input_area_bytes_out      = aod_pkg::INPUT_BYTES;

    ////////////////////////////////////////////////////////////////////
    // microsecond ticker
    aod_us_ticker u_ticker (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .tick        (tick_bus.src)
    );

    // status indicators
    aod_status_led #(
        .BLINK_HALF_US (BLINK_HALF_US)
    ) u_led (
        .core_clk_in                (core_clk_in),
        .nrst_in                    (nrst_in),
        .bus_comm_ok_in             (bus_comm_ok_in),
        .bus_supply_err_in          (bus_supply_err_in),
        .cfg_err_any_in             (|cfg_err_in),
        .err_any_in                 (|err_vec),
        .chan_err_in                (chan_any),
        .tick                       (tick_bus.snk),
        .run_led_out                (run_led_out),
        .module_fault_indicator_out (module_fault_indicator_out),
        .chan_led_out               (chan_led_out)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    ext_flags_a: assert property (
        st_r.ext_err[aod_pkg::EXT_OVF_BIT] == $past(diag_ovf_in) &&
        st_r.ext_err[aod_pkg::EXT_COMM_BIT] == $past(comm_err_in) &&
        (st_r.ext_err & 8'he7) == 8'h00)
        else $error("extended error byte wrong");

    kind_read_a: assert property (
        (rec_rd_en_in && rec_rd_addr_in == aod_pkg::REC_KIND)
        |=> rec_rd_valid_out && rec_rd_data_out == 8'h73)
        else $error("channel kind byte wrong");

    bitcount_read_a: assert property (
        (rec_rd_en_in && rec_rd_addr_in == aod_pkg::REC_BITS_PER_CH)
        |=> rec_rd_data_out == 8'h08)
        else $error("diagnostic bit count wrong");

    chcount_read_a: assert property (
        (rec_rd_en_in && rec_rd_addr_in == aod_pkg::REC_CHAN_COUNT)
        |=> rec_rd_data_out == 8'h02)
        else $error("channel count wrong");

    summary_bits_a: assert property (
        st_r.summary == {6'h00, $past(chan_any)})
        else $error("channel error summary wrong");

    chan_byte_a: assert property (
        st_r.ch_err[1] ==
        {3'h0, $past(wire_break_in[1]), 3'h0, $past(cfg_err_in[1])})
        else $error("channel error byte wrong");

    stamp_capture_a: assert property (
        diag_event |=> st_r.stamp == $past(tick_bus.count))
        else $error("timestamp not captured");
    stamp_hold_a: assert property (
        !diag_event |=> $stable(st_r.stamp))
        else $error("timestamp changed without event");

    // channel 1 write lands at offset two
    ch1_write_a: assert property (
        (out_wr_en_in && out_wr_offset_in == aod_pkg::OUT_OFS_CH1)
        |=> channel1_output_value_out == $past(out_wr_data_in) &&
            $stable(channel0_output_value_out))
        else $error("channel 1 write misplaced");

    input_area_a: assert property (
        input_area_bytes_out == 8'h00)
        else $error("input area reported in use");

    event_capture_c: cover property (diag_event ##1 !diag_event);
    stamp_read_c: cover property (
        rec_rd_en_in && rec_rd_addr_in == aod_pkg::REC_STAMP3);
    ch0_write_c: cover property (
        out_wr_en_in && out_wr_offset_in == aod_pkg::OUT_OFS_CH0);

endmodule : aod_diag_record

// File: aod_pkg.sv
// constants shared by the analog output diagnostic record block
package aod_pkg;

    ////////////////////////////////////////////////////////////////////
    // diagnostic record byte indices
    localparam logic [4:0] REC_ERR_A   = 5'h00;
    localparam logic [4:0] REC_MODTYP  = 5'h01;
    localparam logic [4:0] REC_ERR_C   = 5'h02;
    localparam logic [4:0] REC_EXT_ERR = 5'h03;
    localparam logic [4:0] REC_KIND    = 5'h04;
    localparam logic [4:0] REC_BITS_PER_CH = 5'h05;
    localparam logic [4:0] REC_CHAN_COUNT  = 5'h06;
    localparam logic [4:0] REC_SUMMARY = 5'h07;
    localparam logic [4:0] REC_CH0     = 5'h08;
    localparam logic [4:0] REC_CH1     = 5'h09;
    localparam logic [4:0] REC_STAMP0  = 5'h10;
    localparam logic [4:0] REC_STAMP1  = 5'h11;
    localparam logic [4:0] REC_STAMP2  = 5'h12;
    localparam logic [4:0] REC_STAMP3  = 5'h13;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int EXT_OVF_BIT  = 3;
    localparam int EXT_COMM_BIT = 4;
    localparam int SUM_GRP0_BIT = 0;
    localparam int CH_CFG_BIT   = 0;
    localparam int CH_WB_BIT    = 4;

    ////////////////////////////////////////////////////////////////////
    // channel kind codes, bit 7 reserved as zero
    localparam logic [6:0] KIND_DIG_IN  = 7'h70;
    localparam logic [6:0] KIND_ANA_IN  = 7'h71;
    localparam logic [6:0] KIND_DIG_OUT = 7'h72;
    localparam logic [6:0] KIND_ANA_OUT = 7'h73;
    localparam logic [6:0] KIND_ANA_IO  = 7'h74;
    localparam logic [6:0] KIND_COUNTER = 7'h76;

    // fixed record contents
    localparam logic [7:0] DIAG_BITS   = 8'h08;
    localparam logic [7:0] CHAN_COUNT  = 8'h02;
    localparam logic [7:0] INPUT_BYTES = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // output area byte offsets
    localparam logic [1:0] OUT_OFS_CH0 = 2'h0;
    localparam logic [1:0] OUT_OFS_CH1 = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS         = 1000;
    localparam int PRE_CYCLES    = US_NS / CLK_PERIOD_NS;
    localparam int BLINK_HALF_US = 250000;

    // status indicator modes
    typedef enum logic [1:0] {
        LED_DARK,
        LED_COMM_LOST,
        LED_CFG_BLINK,
        LED_NORMAL
    } aod_led_e;

endpackage : aod_pkg

// File: aod_tick_if.sv
// microsecond ticker carrier between ticker and its users
`timescale 1ns/1ps

interface aod_tick_if;
    logic [31:0] count;
    logic        us_pulse;
    modport src (output count, output us_pulse);
    modport snk (input count, input us_pulse);
endinterface : aod_tick_if

// File: aod_us_ticker.sv
// free-running 32-bit microsecond ticker with clock prescaler
`timescale 1ns/1ps

module aod_us_ticker (
    input  wire logic core_clk_in,
    input  wire logic nrst_in,
    aod_tick_if.src   tick
);

    localparam logic [6:0] PRE_MAX = 7'(aod_pkg::PRE_CYCLES - 1);

    typedef struct packed {
        logic [6:0]  pre;
        logic [31:0] count;
    } aod_tick_s;

    aod_tick_s st_r;
    aod_tick_s st_nxt;

    ////////////////////////////////////////////////////////////////////
    // prescaler and counter
    // one step per microsecond
    always_comb begin
        st_nxt = st_r;
        if (st_r.pre == PRE_MAX) begin
            st_nxt.pre = '0;
            st_nxt.count = st_r.count + 32'h0000_0001;
        end else begin
            st_nxt.pre = st_r.pre + 7'h01;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick.count    = st_r.count;
    assign tick.us_pulse = (st_r.pre == PRE_MAX);

    ////////////////////////////////////////////////////////////////////
    // checks
    // pulses spaced apart
    pulse_spacing_a: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) tick.us_pulse |=> !tick.us_pulse [*8])
        else $error("microsecond pulses too close");
    ticker_wrap_a: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        tick.us_pulse |=> tick.count == 32'($past(tick.count) + 32'h1))
        else $error("ticker did not step by one");
    // counts up only on the pulse
    ticker_step_a: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        !tick.us_pulse |=> tick.count == $past(tick.count))
        else $error("ticker moved without a pulse");

endmodule : aod_us_ticker

// File: aod_status_led.sv
// run, module fault and channel indicator control
`timescale 1ns/1ps

module aod_status_led #(
    parameter int BLINK_HALF_US = aod_pkg::BLINK_HALF_US
) (
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       bus_comm_ok_in,
    input  wire logic       bus_supply_err_in,
    input  wire logic       cfg_err_any_in,
    input  wire logic       err_any_in,
    input  wire logic [1:0] chan_err_in,
    aod_tick_if.snk         tick,
    output logic            run_led_out,
    output logic            module_fault_indicator_out,
    output logic [1:0]      chan_led_out
);

    localparam logic [17:0] BLINK_MAX = 18'(BLINK_HALF_US - 1);

    typedef struct packed {
        logic        run;
        logic        fault;
        logic [1:0]  chan;
        logic [17:0] blink_cnt;
        logic        blink_ph;
    } aod_led_s;

    aod_led_s         st_r;
    aod_led_s         st_nxt;
    aod_pkg::aod_led_e mode;

    ////////////////////////////////////////////////////////////////////
    // mode priority: supply, then link, then configuration
    always_comb begin
        if (bus_supply_err_in) begin
            mode = aod_pkg::LED_DARK;
        end else if (!bus_comm_ok_in) begin
            mode = aod_pkg::LED_COMM_LOST;
        end else if (cfg_err_any_in) begin
            mode = aod_pkg::LED_CFG_BLINK;
        end else begin
            mode = aod_pkg::LED_NORMAL;
        end
    end

    // indicator outputs and 2 Hz blink timebase
    always_comb begin
        st_nxt = st_r;
        if (tick.us_pulse) begin
            if (st_r.blink_cnt == BLINK_MAX) begin
                st_nxt.blink_cnt = '0;
                st_nxt.blink_ph  = !st_r.blink_ph;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 18'h00001;
            end
        end
        st_nxt.chan = chan_err_in;
        unique case (mode)
            aod_pkg::LED_DARK: begin
                st_nxt.run   = 1'b0;
                st_nxt.fault = 1'b0;
            end
            // link lost, run off, fault on
            aod_pkg::LED_COMM_LOST: begin
                st_nxt.run   = 1'b0;
                st_nxt.fault = 1'b1;
            end
            aod_pkg::LED_CFG_BLINK: begin
                st_nxt.run   = 1'b1;
                st_nxt.fault = st_r.blink_ph;
            end
            aod_pkg::LED_NORMAL: begin
                st_nxt.run   = 1'b1;
                st_nxt.fault = err_any_in;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign run_led_out                = st_r.run;
    assign module_fault_indicator_out = st_r.fault;
    assign chan_led_out               = st_r.chan;

    ////////////////////////////////////////////////////////////////////
    // checks
    // supply error darkens both
    supply_dark_a: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        bus_supply_err_in |=> !run_led_out && !module_fault_indicator_out)
        else $error("indicator lit during supply error");
    comm_lost_a: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (!bus_comm_ok_in && !bus_supply_err_in)
        |=> !run_led_out && module_fault_indicator_out)
        else $error("wrong indication for lost link");
    blink_seen_c: cover property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (mode == aod_pkg::LED_CFG_BLINK) && $rose(st_r.blink_ph));

endmodule : aod_status_led

// File: aod_host_model.sv
// host model: reads the diagnostic record and writes the output area
`timescale 1ns/1ps

module aod_host_model (
    input  wire logic        core_clk_in,
    output logic             rd_en_out,
    output logic      [4:0]  rd_addr_out,
    output logic             wr_en_out,
    output logic      [1:0]  wr_ofs_out,
    output logic      [15:0] wr_data_out
);
    // idle bus from time zero
    initial begin
        rd_en_out   = 1'b0;
        rd_addr_out = 5'h00;
        wr_en_out   = 1'b0;
        wr_ofs_out  = 2'h0;
        wr_data_out = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // one record byte read, address scrambled once released
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk_in);
        rd_en_out   <= 1'b1;
        rd_addr_out <= a;
        @(posedge core_clk_in);
        rd_en_out   <= 1'b0;
        rd_addr_out <= ~a;
    endtask : rd

    task automatic wr(input logic [1:0] o, input logic [15:0] d);
        @(posedge core_clk_in);
        wr_en_out   <= 1'b1;
        wr_ofs_out  <= o;
        wr_data_out <= d;
        @(posedge core_clk_in);
        wr_en_out   <= 1'b0;
        wr_data_out <= ~d;
    endtask : wr
endmodule : aod_host_model

// File: test_analog_output_diag_record.sv
// self-checking bench for the analog output diagnostic record
`timescale 1ns/1ps

module test_analog_output_diag_record;
    logic        core_clk_in;
    logic        nrst_in;
    logic        rd_en;
    logic [4:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        wr_en;
    logic [1:0]  wr_ofs;
    logic [15:0] wr_data;
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [1:0]  cfg_err;
    logic [1:0]  wire_brk;
    logic        diag_ovf;
    logic        comm_err;
    logic        comm_ok;
    logic        sup_err;
    logic        run_led;
    logic        fault_led;
    logic [1:0]  chan_led;
    logic [7:0]  in_bytes;
    logic [7:0]  expq[$];
    logic [31:0] v;
    int          n_fail;
    int          checked;
    int          cyc;
    int          tcount;
    int          seed;

    aod_diag_record #(.BLINK_HALF_US(4)) dut_u (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .rec_rd_en_in(rd_en), .rec_rd_addr_in(rd_addr),
        .rec_rd_data_out(rd_data), .rec_rd_valid_out(rd_valid),
        .out_wr_en_in(wr_en), .out_wr_offset_in(wr_ofs),
        .out_wr_data_in(wr_data),
        .channel0_output_value_out(ch0),
        .channel1_output_value_out(ch1),
        .cfg_err_in(cfg_err), .wire_break_in(wire_brk),
        .diag_ovf_in(diag_ovf), .comm_err_in(comm_err),
        .bus_comm_ok_in(comm_ok), .bus_supply_err_in(sup_err),
        .run_led_out(run_led), .module_fault_indicator_out(fault_led),
        .chan_led_out(chan_led), .input_area_bytes_out(in_bytes)
    );

    aod_host_model host_u (
        .core_clk_in(core_clk_in), .rd_en_out(rd_en),
        .rd_addr_out(rd_addr), .wr_en_out(wr_en),
        .wr_ofs_out(wr_ofs), .wr_data_out(wr_data)
    );

    ////////////////////////////////////////////////////////////////////
    // clock, cycle count since release, hang limit
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        cyc    <= (nrst_in === 1'b1) ? cyc + 1 : 0;
        tcount <= tcount + 1;
        if (tcount == 30000) begin
            n_fail++;
            close_out();
        end
    end

    // read results taken off the queue as they appear
    always @(posedge core_clk_in) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0)
                check(32'h1, 32'h0);
            else
                check({24'h0, rd_data}, {24'h0, expq.pop_front()});
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, e);
        end
    endtask : check

    // note the expected byte, then let the host read it
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        expq.push_back(e);
        host_u.rd(a);
    endtask : rd_chk

    // raise a wire-break at a chosen microsecond, then read the stamp
    task automatic stamp_at(input int k);
        logic [31:0] e;
        e = k;
        wire_brk <= 2'b00;
        @(posedge core_clk_in);
        while (cyc < k * 125 + 60) @(posedge core_clk_in);
        wire_brk <= 2'b01;
        repeat (3) @(posedge core_clk_in);
        for (int b = 0; b < 4; b++) rd_chk(5'h10 + b[4:0], e[8*b +: 8]);
        wire_brk <= 2'b00;
    endtask : stamp_at

    // set supply and link state, then look at both indicators
    task automatic led(input logic s, input logic ok, input logic [1:0] e);
        @(posedge core_clk_in);
        sup_err <= s;
        comm_ok <= ok;
        repeat (3) @(posedge core_clk_in);
        @(negedge core_clk_in);
        check({30'h0, run_led, fault_led}, {30'h0, e});
    endtask : led

    task automatic close_out;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 32'hdcae;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        tcount = 0;
        nrst_in = 1'b0;
        cfg_err = 2'h0;
        wire_brk = 2'h0;
        diag_ovf = 1'b0;
        comm_err = 1'b0;
        comm_ok = 1'b1;
        sup_err = 1'b0;
        repeat (5) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        stamp_at(0);
        rd_chk(aod_pkg::REC_KIND, 8'h73);
        rd_chk(aod_pkg::REC_BITS_PER_CH, 8'h08);
        rd_chk(aod_pkg::REC_CHAN_COUNT, 8'h02);
        for (int i = 10; i < 16; i++) rd_chk(i[4:0], 8'h00);
        check({24'h0, in_bytes}, 32'h0);
        stamp_at(37);
        // random error levels against the record bytes
        for (int n = 0; n < 12; n++) begin
            v = $random(seed);
            @(posedge core_clk_in);
            cfg_err <= v[1:0];
            wire_brk <= v[3:2];
            diag_ovf <= v[4];
            comm_err <= v[5];
            repeat (2) @(posedge core_clk_in);
            check({30'h0, chan_led}, {30'h0, v[1:0] | v[3:2]});
            rd_chk(aod_pkg::REC_EXT_ERR, {3'h0, v[5:4], 3'h0});
            rd_chk(aod_pkg::REC_SUMMARY, {6'h0, v[1:0] | v[3:2]});
            rd_chk(aod_pkg::REC_CH0, {3'h0, v[2], 3'h0, v[0]});
            rd_chk(aod_pkg::REC_CH1, {3'h0, v[3], 3'h0, v[1]});
        end
        @(posedge core_clk_in);
        {cfg_err, wire_brk, diag_ovf, comm_err} <= 6'h00;
        // output words, odd offsets ignored
        for (int n = 0; n < 4; n++) begin
            v = $random(seed);
            host_u.wr(aod_pkg::OUT_OFS_CH0, v[15:0]);
            host_u.wr(aod_pkg::OUT_OFS_CH1, v[31:16]);
            host_u.wr(2'h1, ~v[15:0]);
            host_u.wr(2'h3, ~v[31:16]);
            @(negedge core_clk_in);
            check({16'h0, ch0}, {16'h0, v[15:0]});
            check({16'h0, ch1}, {16'h0, v[31:16]});
        end
        // indicator states
        led(1'b1, 1'b0, 2'b00);
        led(1'b1, 1'b1, 2'b00);
        led(1'b0, 1'b0, 2'b01);
        led(1'b0, 1'b1, 2'b10);
        // second reset in mid-run clears outputs and the ticker
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        check({ch1, ch0}, 32'h0);
        nrst_in <= 1'b1;
        stamp_at(0);
        repeat (4) @(posedge core_clk_in);
        check(expq.size(), 32'h0);
        close_out();
    end
endmodule : test_analog_output_diag_record
